// ===== logic/lsvcd_params.svh
// offsets, field positions, reset values and checksum constants of the servo command decoder
// assumes inclusion by the decoder module only
`ifndef LSVCD_PARAMS_SVH
`define LSVCD_PARAMS_SVH

// register byte addresses
`define LSVCD_CTRL_ADDR     8'h00
`define LSVCD_STATUS_ADDR   8'h04
`define LSVCD_DATA_ADDR     8'h08
`define LSVCD_POS_ADDR      8'h0c

// control register fields
`define LSVCD_CTRL_RX_EN    0
`define LSVCD_CTRL_RESET    32'h0000_0001

// status register fields
`define LSVCD_ST_OC         0
`define LSVCD_ST_STOPPED    1
`define LSVCD_ST_FWD        2
`define LSVCD_ST_REV        3
`define LSVCD_ST_PAR_ERR    4
`define LSVCD_ST_OT         5
`define LSVCD_ST_CS_ERR     6
`define LSVCD_ST_OV         7

// request byte fields
`define LSVCD_RQ_CLR_COMM   0
`define LSVCD_RQ_CLR_DIAG   1
`define LSVCD_RQ_SOFT       2
`define LSVCD_RQ_PERIOD     3
`define LSVCD_RQ_DUTY_LO    4
`define LSVCD_RQ_DUTY_HI    5
`define LSVCD_RQ_ESTOP      6
`define LSVCD_RQ_RECOVER    7

// byte values
`define LSVCD_BYTE_ZERO     8'h00
`define LSVCD_BYTE_ONES     8'hff

`endif

// ===== logic/lsvcd_pkg.sv
// types shared by the servo command decoder
// assumes lsvcd_params.svh holds the numeric constants
package lsvcd_pkg;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_TARGET,
        RX_REQUEST,
        RX_CHECK
    } lsvcd_rx_t;

    typedef enum logic [2:0] {
        MOT_STOP,
        MOT_FWD,
        MOT_REV,
        MOT_FORCE_FWD,
        MOT_FORCE_REV
    } lsvcd_mot_t;

endpackage

// ===== logic/lsvcd_top.sv
// servo command decoder: reception frame check, commit and motor direction control
// assumes a byte receiver and an id filter on hclk; adc and detectors are on hclk too
`timescale 1ns/1ps
`include "lsvcd_params.svh"

// Summary of operation
// - accept only own-id, receive-length, parity-clean frames
// - first byte goes to temp target, reset zero
// - good framed second byte goes to temp request
// - bad framing drops data, sets both error flags
// - temp request cleared at reset
// - checksum sum all ones commits both bytes
// - bad sum flags checksum error, discards frame
// - start comparison only when target changed or recovery requested
// - target above position drives forward
// - target below position drives reverse
// - stop and flag when position reaches target
// - equal target holds outputs low, stopped
// - recovery with zero target forces reverse
// - recovery with all ones forces forward
// - forced rotation ignores soft ramp, keeps duty
// - bit zero clears parity and checksum flags
// - bit one clears protection flags
// - bit two enables soft start and stop
// - bit three picks 500 or 250 ms
// - bits four, five pick maximum duty
// - bit six stops motor at once
// - emergency stop beats recovery
// - bit seven resumes toward unchanged target
// - recovery ignored while over current set
module lsvcd_top (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // identifier result from the frame receiver
    input  wire logic        id_valid,
    input  wire logic        id_match,
    input  wire logic        length_select_low,
    input  wire logic        length_select_high,
    input  wire logic        id_parity_error,
    // received bytes
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    input  wire logic        byte_start_bit,
    input  wire logic        byte_stop_bit,
    // position and protection
    input  wire logic [7:0]  position,
    input  wire logic        over_current_event,
    input  wire logic        over_temp_event,
    input  wire logic        over_volt_event,
    input  wire logic        standby,
    // motor and pwm settings
    output logic             motor_out_a,
    output logic             motor_out_b,
    output logic             soft_start_en,
    output logic             torque_period_500,
    output logic [1:0]       max_duty_sel,
    output logic             commit_pulse
);

    lsvcd_pkg::lsvcd_rx_t  rx_state;
    lsvcd_pkg::lsvcd_rx_t  next_rx_state;
    lsvcd_pkg::lsvcd_mot_t mot_state;
    lsvcd_pkg::lsvcd_mot_t next_mot_state;

    logic [7:0]  tmp_target;
    logic [7:0]  tmp_request;
    logic [7:0]  checksum_hold;
    logic [7:0]  target_position_byte;
    logic [7:0]  request_byte;
    logic [7:0]  prev_target;
    logic        act_pending;
    logic        rx_enable;
    logic        parity_err_flag;
    logic        cs_err_flag;
    logic        oc_flag;
    logic        ot_flag;
    logic        ov_flag;
    logic        stopped_flag;
    logic        forward_rotation_flag;
    logic        reverse_rotation_flag;

    // ahb address phase capture
    logic        dp_write;
    logic [7:0]  dp_addr;

    function automatic logic [7:0] lsvcd_sum(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic [7:0] c);
        logic [8:0] s1;
        s1 = {1'b0, a} + {1'b0, b};
        lsvcd_sum = s1[7:0] + {7'h00, s1[8]} + c;
    endfunction

    function automatic logic lsvcd_drives(input lsvcd_pkg::lsvcd_mot_t s, input logic fwd);
        if (fwd) begin
            lsvcd_drives = (s == lsvcd_pkg::MOT_FWD) || (s == lsvcd_pkg::MOT_FORCE_FWD);
        end else begin
            lsvcd_drives = (s == lsvcd_pkg::MOT_REV) || (s == lsvcd_pkg::MOT_FORCE_REV);
        end
    endfunction

    // ---------------- register bus ----------------
    wire        ap_valid   = hsel && htrans[1] && hready;
    wire        bus_write  = dp_write && (dp_addr == `LSVCD_CTRL_ADDR);
    wire [31:0] status_word = {20'h00000, 1'b0, rx_state == lsvcd_pkg::RX_IDLE,
                               motor_out_b, motor_out_a,
                               ov_flag, cs_err_flag, ot_flag, parity_err_flag,
                               reverse_rotation_flag, forward_rotation_flag,
                               stopped_flag, oc_flag};
    wire [31:0] data_word   = {checksum_hold, 8'h00, request_byte, target_position_byte};
    wire [7:0]  ap_addr     = haddr[7:0];
    wire        ap_hit_hi   = (haddr[31:8] == 24'h000000);
    wire [31:0] read_mux    =
        !ap_hit_hi                      ? 32'h0000_0000 :
        (ap_addr == `LSVCD_CTRL_ADDR)   ? {31'h0000_0000, rx_enable} :
        (ap_addr == `LSVCD_STATUS_ADDR) ? status_word :
        (ap_addr == `LSVCD_DATA_ADDR)   ? data_word :
        (ap_addr == `LSVCD_POS_ADDR)    ? {24'h000000, position} :
                                          32'h0000_0000;

    // zero wait states: read data is fetched at the address phase edge
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
            hrdata   <= 32'h0000_0000;
        end else begin
            dp_write <= ap_valid && hwrite && ap_hit_hi;
            dp_addr  <= ap_addr;
            if (ap_valid && !hwrite) begin
                hrdata <= read_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_enable <= 1'(`LSVCD_CTRL_RESET);
        end else if (bus_write) begin
            rx_enable <= hwdata[`LSVCD_CTRL_RX_EN];
        end
    end

    // ---------------- reception ----------------
    wire id_accept  = rx_enable && id_match && length_select_low
                      && !length_select_high && !id_parity_error;
    // the parity result means nothing outside the identifier pulse
    wire id_par_bad = id_valid && rx_enable && id_match && id_parity_error;
    wire frame_ok   = !byte_start_bit && byte_stop_bit;
    wire frame_bad  = byte_valid && !frame_ok && (rx_state != lsvcd_pkg::RX_IDLE);
    wire take_tgt   = byte_valid && frame_ok && (rx_state == lsvcd_pkg::RX_TARGET);
    wire take_req   = byte_valid && frame_ok && (rx_state == lsvcd_pkg::RX_REQUEST);
    wire take_cs    = byte_valid && frame_ok && (rx_state == lsvcd_pkg::RX_CHECK);
    wire sum_ok     = lsvcd_sum(tmp_target, tmp_request, byte_data) == `LSVCD_BYTE_ONES;
    wire do_commit  = take_cs && sum_ok;
    wire cs_bad     = take_cs && !sum_ok;

    always_comb begin
        next_rx_state = rx_state;
        if (id_valid) begin
            next_rx_state = id_accept ? lsvcd_pkg::RX_TARGET : lsvcd_pkg::RX_IDLE;
        end else if (byte_valid) begin
            unique case (rx_state)
                lsvcd_pkg::RX_IDLE:    next_rx_state = lsvcd_pkg::RX_IDLE;
                lsvcd_pkg::RX_TARGET:  next_rx_state = frame_ok ? lsvcd_pkg::RX_REQUEST
                                                                : lsvcd_pkg::RX_IDLE;
                lsvcd_pkg::RX_REQUEST: next_rx_state = frame_ok ? lsvcd_pkg::RX_CHECK
                                                                : lsvcd_pkg::RX_IDLE;
                lsvcd_pkg::RX_CHECK:   next_rx_state = lsvcd_pkg::RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_state      <= lsvcd_pkg::RX_IDLE;
            tmp_target    <= `LSVCD_BYTE_ZERO;
            tmp_request   <= `LSVCD_BYTE_ZERO;
            checksum_hold <= `LSVCD_BYTE_ZERO;
        end else begin
            rx_state <= next_rx_state;
            if (take_tgt) begin
                tmp_target <= byte_data;
            end
            if (take_req) begin
                tmp_request <= byte_data;
            end
            if (take_cs) begin
                checksum_hold <= byte_data;
            end
        end
    end

    // official data; the request acts one cycle later so the commit is settled first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            target_position_byte <= `LSVCD_BYTE_ZERO;
            request_byte         <= `LSVCD_BYTE_ZERO;
            prev_target          <= `LSVCD_BYTE_ZERO;
            act_pending          <= 1'b0;
        end else begin
            act_pending <= do_commit;
            if (do_commit) begin
                target_position_byte <= tmp_target;
                request_byte         <= tmp_request;
                prev_target          <= target_position_byte;
            end
        end
    end

    assign commit_pulse = act_pending;

    // ---------------- error and protection flags ----------------
    // a new error in the clearing cycle wins over the clear
    wire clr_comm = act_pending && request_byte[`LSVCD_RQ_CLR_COMM];
    wire clr_diag = act_pending && request_byte[`LSVCD_RQ_CLR_DIAG];
    wire set_par  = frame_bad || id_par_bad;
    wire set_cs   = frame_bad || cs_bad;
    wire diag_any = oc_flag || ot_flag || ov_flag;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            parity_err_flag <= 1'b0;
            cs_err_flag     <= 1'b0;
            oc_flag         <= 1'b0;
            ot_flag         <= 1'b0;
            ov_flag         <= 1'b0;
        end else if (standby) begin
            parity_err_flag <= 1'b0;
            cs_err_flag     <= 1'b0;
            oc_flag         <= 1'b0;
            ot_flag         <= 1'b0;
            ov_flag         <= 1'b0;
        end else begin
            parity_err_flag <= set_par || (parity_err_flag && !clr_comm);
            cs_err_flag     <= set_cs || (cs_err_flag && !clr_comm);
            oc_flag <= over_current_event || (oc_flag && !clr_diag);
            ot_flag <= over_temp_event || (ot_flag && !clr_diag);
            ov_flag <= over_volt_event || (ov_flag && !clr_diag);
        end
    end

    // ---------------- motor control ----------------
    wire rq_estop   = request_byte[`LSVCD_RQ_ESTOP];
    wire rq_recover = request_byte[`LSVCD_RQ_RECOVER] && !oc_flag;
    wire tgt_change = target_position_byte != prev_target;
    wire tgt_zero   = target_position_byte == `LSVCD_BYTE_ZERO;
    wire tgt_ones   = target_position_byte == `LSVCD_BYTE_ONES;
    wire halt_now   = standby || diag_any
                      || over_current_event || over_temp_event || over_volt_event;

    lsvcd_pkg::lsvcd_mot_t seek_state;
    assign seek_state = (target_position_byte > position) ? lsvcd_pkg::MOT_FWD :
                        (target_position_byte < position) ? lsvcd_pkg::MOT_REV :
                                                            lsvcd_pkg::MOT_STOP;

    always_comb begin
        next_mot_state = mot_state;
        if (halt_now) begin
            next_mot_state = lsvcd_pkg::MOT_STOP;
        end else if (act_pending && rq_estop) begin
            next_mot_state = lsvcd_pkg::MOT_STOP;
        end else if (act_pending && rq_recover && tgt_zero) begin
            next_mot_state = lsvcd_pkg::MOT_FORCE_REV;
        end else if (act_pending && rq_recover && tgt_ones) begin
            next_mot_state = lsvcd_pkg::MOT_FORCE_FWD;
        end else if (act_pending && (rq_recover || tgt_change)) begin
            next_mot_state = seek_state;
        end else begin
            unique case (mot_state)
                lsvcd_pkg::MOT_FWD: if (position >= target_position_byte) begin
                    next_mot_state = lsvcd_pkg::MOT_STOP;
                end
                lsvcd_pkg::MOT_REV: if (position <= target_position_byte) begin
                    next_mot_state = lsvcd_pkg::MOT_STOP;
                end
                lsvcd_pkg::MOT_STOP,
                lsvcd_pkg::MOT_FORCE_FWD,
                lsvcd_pkg::MOT_FORCE_REV: next_mot_state = mot_state;
            endcase
        end
    end

    wire next_fwd  = lsvcd_drives(next_mot_state, 1'b1);
    wire next_rev  = lsvcd_drives(next_mot_state, 1'b0);
    wire was_drive = motor_out_a || motor_out_b;
    wire settle    = act_pending && !halt_now && (next_mot_state == lsvcd_pkg::MOT_STOP);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mot_state             <= lsvcd_pkg::MOT_STOP;
            motor_out_a           <= 1'b0;
            motor_out_b           <= 1'b0;
            forward_rotation_flag <= 1'b0;
            reverse_rotation_flag <= 1'b0;
            stopped_flag          <= 1'b0;
        end else begin
            mot_state             <= next_mot_state;
            motor_out_a           <= next_fwd;
            motor_out_b           <= next_rev;
            forward_rotation_flag <= next_fwd;
            reverse_rotation_flag <= next_rev;
            if (next_fwd || next_rev) begin
                stopped_flag <= 1'b0;
            end else if (was_drive || settle) begin
                stopped_flag <= 1'b1;
            end
        end
    end

    // pwm settings follow the committed request; forced runs never ramp
    wire forced_next = (next_mot_state == lsvcd_pkg::MOT_FORCE_FWD)
                       || (next_mot_state == lsvcd_pkg::MOT_FORCE_REV);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            soft_start_en     <= 1'b0;
            torque_period_500 <= 1'b0;
            max_duty_sel      <= 2'h0;
        end else begin
            soft_start_en     <= request_byte[`LSVCD_RQ_SOFT] && !forced_next;
            torque_period_500 <= request_byte[`LSVCD_RQ_PERIOD];
            max_duty_sel      <= {request_byte[`LSVCD_RQ_DUTY_HI],
                                  request_byte[`LSVCD_RQ_DUTY_LO]};
        end
    end

    // ---------------- checks ----------------
    sequence good_check_s;
        take_cs && sum_ok;
    endsequence

    sequence committed_s;
        act_pending && (target_position_byte == $past(tmp_target));
    endsequence

    commit_on_sum_a: assert property (@(posedge hclk) disable iff (!hresetn)
        good_check_s |=> committed_s)
        else $error("good checksum did not commit target");

    bad_sum_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cs_bad && !standby |=> cs_err_flag && !act_pending && $stable(request_byte))
        else $error("bad checksum not flagged or data committed");

    bad_frame_a: assert property (@(posedge hclk) disable iff (!hresetn)
        frame_bad && !standby |=> parity_err_flag && cs_err_flag
                                  && rx_state == lsvcd_pkg::RX_IDLE)
        else $error("bad framing not flagged");

    foreign_id_a: assert property (@(posedge hclk) disable iff (!hresetn)
        id_valid && !id_accept |=> rx_state == lsvcd_pkg::RX_IDLE)
        else $error("foreign frame accepted");

    fwd_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
        motor_out_a |-> !motor_out_b && forward_rotation_flag && !stopped_flag)
        else $error("forward drive outputs inconsistent");

    reach_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mot_state == lsvcd_pkg::MOT_FWD && !act_pending
        && position >= target_position_byte |=> !motor_out_a && stopped_flag)
        else $error("motor kept running at target");

    estop_win_a: assert property (@(posedge hclk) disable iff (!hresetn)
        act_pending && rq_estop |=> !motor_out_a && !motor_out_b)
        else $error("emergency stop not obeyed");

    oc_recover_a: assert property (@(posedge hclk) disable iff (!hresetn)
        act_pending && oc_flag |=> !motor_out_a && !motor_out_b)
        else $error("recovery acted with over current set");

    comm_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        clr_comm && !set_par && !set_cs |=> !parity_err_flag && !cs_err_flag)
        else $error("communication flags not cleared");

    forced_soft_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mot_state == lsvcd_pkg::MOT_FORCE_FWD |-> !soft_start_en)
        else $error("soft ramp active in forced rotation");

endmodule // lsvcd_top

// ===== dv/lsvcd_lin_master.sv
// bus master model: identifier results and received bytes of reception frames
// assumes the decoder samples every pulse on the rising edge of hclk
`timescale 1ns/1ps
module lsvcd_lin_master (
    // clock
    input  wire logic       hclk,
    // identifier result
    output logic            id_valid,
    output logic            id_match,
    output logic            length_select_low,
    output logic            length_select_high,
    output logic            id_parity_error,
    // received byte
    output logic            byte_valid,
    output logic [7:0]      byte_data,
    output logic            byte_start_bit,
    output logic            byte_stop_bit
);
    initial begin
        {id_valid, id_match, id_parity_error} = 3'b000;
        {length_select_low, length_select_high} = 2'b00;
        {byte_valid, byte_data, byte_start_bit, byte_stop_bit} = 11'h000;
    end

    // kind: 2 bad stop bit on byte two, 3 foreign id, 4 id parity error, others clean
    task automatic send(input logic [7:0] t, r, cs, input int kind);
        logic [7:0] b [3];
        b = '{t, r, cs};
        @(posedge hclk);
        id_valid <= 1'b1;
        id_match <= (kind != 3);
        length_select_low <= 1'b1;
        length_select_high <= 1'b0;
        id_parity_error <= (kind == 4);
        @(posedge hclk);
        // qualifiers mean nothing outside the pulse, so they do not hold
        id_valid <= 1'b0;
        id_match <= ~id_match;
        id_parity_error <= ~id_parity_error;
        for (int i = 0; i < 3; i++) begin
            @(posedge hclk);
            byte_valid <= 1'b1;
            byte_data <= b[i];
            byte_start_bit <= 1'b0;
            byte_stop_bit <= !(kind == 2 && i == 1);
            @(posedge hclk);
            {byte_valid, byte_start_bit, byte_stop_bit} <= 3'b010;
            byte_data <= ~b[i];
        end
    endtask
endmodule // lsvcd_lin_master

// ===== dv/tb_top.sv
// self-checking bench: ahb-lite register reads plus reception frames from the master model
// assumes one 200 MHz clock; motor position is stepped by the bench
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, max_duty_sel;
    logic [2:0]  hsize;
    logic        id_valid, id_match, length_select_low, length_select_high, id_parity_error;
    logic        byte_valid, byte_start_bit, byte_stop_bit, oc_ev, ot_ev, ov_ev, stby;
    logic [7:0]  byte_data, position, cs;
    logic        motor_out_a, motor_out_b, soft_start_en, torque_period_500, commit_pulse;
    int          fails, n_compared, n_good, n_commit;

    lsvcd_top lsvcd_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .id_valid(id_valid),
        .id_match(id_match), .length_select_low(length_select_low),
        .length_select_high(length_select_high), .id_parity_error(id_parity_error),
        .byte_valid(byte_valid), .byte_data(byte_data), .byte_start_bit(byte_start_bit),
        .byte_stop_bit(byte_stop_bit), .position(position), .over_current_event(oc_ev),
        .over_temp_event(ot_ev), .over_volt_event(ov_ev), .standby(stby),
        .motor_out_a(motor_out_a), .motor_out_b(motor_out_b), .soft_start_en(soft_start_en),
        .torque_period_500(torque_period_500), .max_duty_sel(max_duty_sel),
        .commit_pulse(commit_pulse));
    lsvcd_lin_master lsvcd_lin_master_inst (.hclk(hclk), .id_valid(id_valid),
        .id_match(id_match), .length_select_low(length_select_low),
        .length_select_high(length_select_high), .id_parity_error(id_parity_error),
        .byte_valid(byte_valid), .byte_data(byte_data), .byte_start_bit(byte_start_bit),
        .byte_stop_bit(byte_stop_bit));

    always #2.5 hclk = ~hclk;
    always @(posedge hclk) if (commit_pulse === 1'b1) n_commit++;

    // one single word transfer; called just after a rising edge
    task automatic ahb(input logic wr, input logic [31:0] a, wd, output logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask

    task automatic st(input logic [31:0] m, e);
        ahb(1'b0, 32'h04, 32'h0, rd);
        `CHK("status", e, rd & m)
        `CHK("hresp", 1'b0, hresp)
    endtask

    // kind 0 good, 1 wrong checksum, 5 good but expected to be ignored
    task automatic frm(input logic [7:0] t, r, input int kind);
        logic [8:0] s;
        s = t + r;
        cs = ~(s[7:0] + {7'h00, s[8]});
        if (kind == 1) cs = cs + 8'h01;
        if (kind == 0) n_good++;
        lsvcd_lin_master_inst.send(t, r, cs, kind);
        repeat (6) @(posedge hclk);
    endtask

    task automatic walk(input logic [7:0] p);
        position <= p;
        repeat (4) @(posedge hclk);
    endtask

    task final_report;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        $display("MISMATCH watchdog expected end seen timeout");
        final_report();
    end

    initial begin
        {hclk, hresetn, hsel, hwrite, oc_ev, ot_ev, ov_ev, stby} = 8'h00;
        {haddr, hwdata, htrans, position} = '0;
        hsize = 3'b010;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        st(32'h3ff, 32'h0);
        ahb(1'b0, 32'h08, 32'h0, rd);
        `CHK("data", 32'h0, rd)
        ahb(1'b0, 32'h10, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        ahb(1'b1, 32'h04, 32'hffffffff, rd);
        st(32'h3ff, 32'h0);
        ahb(1'b1, 32'h00, 32'h0, rd);
        frm(8'h80, 8'h00, 5);
        ahb(1'b1, 32'h00, 32'h1, rd);
        ahb(1'b0, 32'h08, 32'h0, rd);
        `CHK("disabled", 32'h0, rd)
        $display("test reset done");
        position <= 8'h40;
        frm(8'h80, 8'h00, 0);
        st(32'h30e, 32'h104);
        ahb(1'b0, 32'h08, 32'h0, rd);
        `CHK("data", {cs, 24'h000080}, rd & 32'hff00ffff)
        ahb(1'b0, 32'h0c, 32'h0, rd);
        `CHK("position", 32'h40, rd)
        walk(8'h80);
        st(32'h30e, 32'h002);
        frm(8'h20, 8'h00, 0);
        st(32'h30e, 32'h208);
        walk(8'h20);
        st(32'h30e, 32'h002);
        position <= 8'h60;
        frm(8'h20, 8'h00, 0);
        st(32'h30e, 32'h002);
        frm(8'h60, 8'h00, 0);
        st(32'h30e, 32'h002);
        $display("test motion done");
        frm(8'h44, 8'h00, 2);
        st(32'h0ff, 32'h052);
        frm(8'h33, 8'h00, 3);
        ahb(1'b0, 32'h08, 32'h0, rd);
        `CHK("kept", 8'h60, rd[7:0])
        frm(8'h60, 8'h01, 0);
        st(32'h0ff, 32'h002);
        frm(8'h33, 8'h01, 1);
        st(32'h0ff, 32'h042);
        ahb(1'b0, 32'h08, 32'h0, rd);
        `CHK("kept", 8'h60, rd[7:0])
        frm(8'h60, 8'h00, 4);
        st(32'h0ff, 32'h052);
        frm(8'h60, 8'h01, 0);
        $display("test errors done");
        for (int i = 0; i < 4; i++) begin
            frm(8'h60, {2'b00, i[1:0], i[0], 1'b1, 2'b00}, 0);
            `CHK("pwm", {1'b1, i[0], i[1:0]}, {soft_start_en, torque_period_500, max_duty_sel})
        end
        $display("test pwm done");
        position <= 8'h30;
        frm(8'h00, 8'h94, 0);
        st(32'h30e, 32'h208);
        `CHK("forced", 3'b001, {soft_start_en, max_duty_sel})
        walk(8'h00);
        st(32'h30e, 32'h208);
        frm(8'h00, 8'h40, 0);
        st(32'h30e, 32'h002);
        frm(8'hff, 8'h84, 0);
        st(32'h30e, 32'h104);
        frm(8'hff, 8'hc0, 0);
        st(32'h30e, 32'h002);
        position <= 8'h40;
        frm(8'h90, 8'h00, 0);
        frm(8'h90, 8'h40, 0);
        st(32'h30e, 32'h002);
        frm(8'h90, 8'h80, 0);
        st(32'h30e, 32'h104);
        walk(8'h90);
        st(32'h30e, 32'h002);
        $display("test recovery done");
        frm(8'h10, 8'h00, 0);
        {oc_ev, ot_ev, ov_ev} <= 3'b111;
        @(posedge hclk);
        {oc_ev, ot_ev, ov_ev} <= 3'b000;
        repeat (3) @(posedge hclk);
        st(32'h3a1, 32'h0a1);
        frm(8'h00, 8'h80, 0);
        st(32'h3a1, 32'h0a1);
        frm(8'h00, 8'h02, 0);
        st(32'h3a1, 32'h0);
        frm(8'hff, 8'h80, 0);
        st(32'h30e, 32'h104);
        stby <= 1'b1;
        @(posedge hclk);
        stby <= 1'b0;
        repeat (3) @(posedge hclk);
        st(32'h30e, 32'h002);
        `CHK("commits", n_good, n_commit)
        $display("test protection done");
        final_report();
    end
endmodule // tb_top
